// ---- sat_pkg.sv ----
/*
   Shared constants for the scheduled action and time sync block: register map, field bits,
   reset values, bus responses, timing constants and the servo state type.
   Assumes a 32-bit AXI4-Lite register bus and a 125 MHz clock.
*/
package sat_pkg;
   localparam int          ADDR_W          = 8;
   localparam int          MAC_W           = 48;
   localparam int          ACC_W           = 8;
   localparam int          TS_W            = 64;
   localparam int          QUEUE_DEPTH_DEF = 4;
   localparam logic [7:0]  OFS_CTRL        = 8'h00;
   localparam logic [7:0]  OFS_STATUS      = 8'h04;
   localparam logic [7:0]  OFS_DEV_KEY     = 8'h08;
   localparam logic [7:0]  OFS_GRP_KEY     = 8'h0c;
   localparam logic [7:0]  OFS_GRP_MASK    = 8'h10;
   localparam logic [7:0]  OFS_SLOT_SEL    = 8'h14;
   localparam logic [7:0]  OFS_QUEUE_DEPTH = 8'h18;
   localparam logic [7:0]  OFS_CLK_ACC     = 8'h1c;
   localparam logic [7:0]  OFS_MAC_LO      = 8'h20;
   localparam logic [7:0]  OFS_MAC_HI      = 8'h24;
   localparam logic [7:0]  OFS_OFFSET      = 8'h28;
   localparam logic [7:0]  OFS_DELAY       = 8'h2c;
   localparam logic [7:0]  OFS_TIME_LO     = 8'h30;
   localparam logic [7:0]  OFS_TIME_HI     = 8'h34;
   localparam int          CTRL_PTE_BIT    = 0;
   localparam int          ST_SYNC_BIT     = 0;
   localparam int          ST_MASTER_BIT   = 1;
   localparam int          ST_QFULL_BIT    = 2;
   localparam logic [31:0] KEY_RST         = 32'h0000_0000;
   localparam logic [31:0] SLOT_FIXED      = 32'h0000_0000;
   localparam logic [7:0]  CLK_ACC_RST     = 8'hfe;
   localparam logic [47:0] MAC_RST         = 48'h0000_0000_0000;
   localparam logic [1:0]  RESP_OKAY       = 2'b00;
   localparam logic [1:0]  RESP_DECERR     = 2'b11;
   localparam logic [63:0] CLK_PERIOD_NS   = 64'h8;
   localparam longint      SYNC_INTERVAL_NS = 1000000000;
   localparam longint      SYNC_INTERVAL_CYC = SYNC_INTERVAL_NS / 8;
   typedef enum logic [1:0] {SRV_OFF, SRV_MASTER, SRV_ACQUIRE, SRV_LOCKED} sat_srv_t;
endpackage

// ---- sat_bmc.sv ----
/*
   Best master clock selection: keeps the best foreign clock heard and compares it with the
   local clock. Assumes announce messages arrive already decoded, on the same clock.
*/
`timescale 1ns/100ps
module sat_bmc (
   // Clock and reset.
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   // Local clock and control.
   input  wire logic                      enable,
   input  wire logic [sat_pkg::ACC_W-1:0] self_acc,
   input  wire logic [sat_pkg::MAC_W-1:0] self_mac,
   // Announce from other clocks.
   input  wire logic                      ann_valid,
   input  wire logic [sat_pkg::ACC_W-1:0] ann_acc,
   input  wire logic [sat_pkg::MAC_W-1:0] ann_mac,
   // Selection result.
   output logic      [sat_pkg::MAC_W-1:0] master_mac,
   output logic                           self_is_master
);
   import sat_pkg::*;
   logic [ACC_W+MAC_W-1:0] best_ff;
   logic [ACC_W+MAC_W-1:0] nxt_best;
   wire  [ACC_W+MAC_W-1:0] ann_rank  = {ann_acc, ann_mac};
   wire  [ACC_W+MAC_W-1:0] self_rank = {self_acc, self_mac};
   wire                    same_src  = ann_mac == best_ff[MAC_W-1:0];
   // Lower accuracy code wins, then the smaller MAC address.
   assign nxt_best = !enable ? '1 :
                     (ann_valid && (ann_rank < best_ff || same_src)) ? ann_rank : best_ff; // RULE_06 RULE_07
   assign self_is_master = self_rank <= best_ff; // RULE_06 RULE_07
   assign master_mac     = self_is_master ? self_mac : best_ff[MAC_W-1:0];
   always_ff @(posedge aclk) begin
      if (!aresetn) best_ff <= '1;
      else best_ff <= nxt_best;
   end
endmodule

// ---- sat_queue.sv ----
/*
   Scheduled action queue: holds action times in arrival order and fires the head entry when
   local time reaches it. Assumes the caller never pushes while full.
*/
`timescale 1ns/100ps
module sat_queue #(
   parameter int DEPTH = sat_pkg::QUEUE_DEPTH_DEF,
   parameter int TW    = sat_pkg::TS_W
) (
   // Clock and reset.
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // Insert side.
   input  wire logic                       push,
   input  wire logic [TW-1:0]              push_ts,
   // Time and firing.
   input  wire logic [TW-1:0]              now,
   output logic                            fire,
   // State.
   output logic      [$clog2(DEPTH+1)-1:0] count,
   output logic                            full
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [TW-1:0]              mem [DEPTH];
   logic [PW-1:0]              rd_ff;
   logic [PW-1:0]              wr_ff;
   logic [$clog2(DEPTH+1)-1:0] cnt_ff;
   wire                        due  = cnt_ff != '0 && now >= mem[rd_ff]; // RULE_17
   wire  [PW-1:0]              rd_n = (rd_ff == PW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
   wire  [PW-1:0]              wr_n = (wr_ff == PW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
   assign fire  = due;
   assign count = cnt_ff; // RULE_04
   assign full  = cnt_ff == ($clog2(DEPTH+1))'(DEPTH);
   always_ff @(posedge aclk) begin
      if (push) mem[wr_ff] <= push_ts;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_ff  <= '0;
         wr_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         rd_ff  <= due ? rd_n : rd_ff;
         wr_ff  <= push ? wr_n : wr_ff;
         cnt_ff <= cnt_ff + (push ? 1'b1 : 1'b0) - (due ? 1'b1 : 1'b0);
      end
   end
endmodule

// ---- sat_top.sv ----
/*
   Scheduled action and precise time sync block: AXI4-Lite registers, local time counter,
   delay-request servo, transparent clock correction and action command filtering.
   Assumes decoded network messages arrive on the same clock as pulses with their fields.
*/
// The implementer's own choices: the address map and register access over AXI4-Lite.
// Contract
// RULE_01: Act only when the command group key equals group_match_key.
// RULE_02: Act only when group masks share at least one set bit of 32.
// RULE_03: Action slot select holds one slot, fixed at index zero.
// RULE_04: Queue depth of scheduled actions is readable.
// RULE_05: Time sync follows precision time protocol version 2 of 2008.
// RULE_06: Best master clock picks the most accurate clock and follows it.
// RULE_07: Equal accuracy: smallest MAC address becomes master.
// RULE_08: Works as end-to-end transparent clock for residence correction.
// RULE_09: Master and slave exchange timestamped messages for delay measurement.
// RULE_10: Path delay derived from the exchanged timestamps.
// RULE_11: Detected offset from master adjusts the local clock.
// RULE_12: Synchronisation repeats periodically to remove drift.
// RULE_13: Sync starts only after precise_time_enable is set.
// RULE_14: Action commands accepted only after sync completes.
// RULE_15: Each accepted broadcast action command starts an exposure.
// RULE_16: Command without time executes on arrival.
// RULE_17: Timed command is queued and fires when local time reaches it.
// RULE_18: Device key mismatch silently drops the command, checked first.
// RULE_19: Full queue drops further timed commands, no overwrite.
`timescale 1ns/100ps
module sat_top #(
   parameter longint SYNC_INTERVAL_CYC = sat_pkg::SYNC_INTERVAL_CYC,
   parameter int     QUEUE_DEPTH       = sat_pkg::QUEUE_DEPTH_DEF
) (
   // Clock and reset.
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // AXI4-Lite write address and data.
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [sat_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   // AXI4-Lite write response.
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   output logic      [1:0]                 s_axi_bresp,
   // AXI4-Lite read.
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   input  wire logic [sat_pkg::ADDR_W-1:0] s_axi_araddr,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   output logic      [31:0]                s_axi_rdata,
   output logic      [1:0]                 s_axi_rresp,
   // Announce messages.
   input  wire logic                       ann_valid,
   input  wire logic [sat_pkg::ACC_W-1:0]  ann_acc,
   input  wire logic [sat_pkg::MAC_W-1:0]  ann_mac,
   // Sync message: master send time and local receive time.
   input  wire logic                       sync_valid,
   input  wire logic [sat_pkg::MAC_W-1:0]  sync_src_mac,
   input  wire logic [sat_pkg::TS_W-1:0]   sync_t1,
   input  wire logic [sat_pkg::TS_W-1:0]   sync_t2,
   // Delay response: local send time and master receive time.
   output logic                            delay_req_start,
   input  wire logic                       dresp_valid,
   input  wire logic [sat_pkg::MAC_W-1:0]  dresp_src_mac,
   input  wire logic [sat_pkg::TS_W-1:0]   dresp_t3,
   input  wire logic [sat_pkg::TS_W-1:0]   dresp_t4,
   // Transparent clock residence correction.
   input  wire logic                       tc_valid,
   input  wire logic [sat_pkg::TS_W-1:0]   tc_ingress_ts,
   input  wire logic [sat_pkg::TS_W-1:0]   tc_egress_ts,
   input  wire logic [sat_pkg::TS_W-1:0]   tc_corr_in,
   output logic                            tc_corr_valid,
   output logic      [sat_pkg::TS_W-1:0]   tc_corr_out,
   // Action commands.
   input  wire logic                       act_valid,
   input  wire logic [31:0]                act_device_key,
   input  wire logic [31:0]                act_group_key,
   input  wire logic [31:0]                act_group_mask,
   input  wire logic                       act_has_time,
   input  wire logic [sat_pkg::TS_W-1:0]   act_time,
   // Exposure and time.
   output logic                            exposure_start,
   output logic      [sat_pkg::TS_W-1:0]   local_time
);
   import sat_pkg::*;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) res[i*8 +: 8] = nw[i*8 +: 8];
      end
      return res;
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return a <= OFS_TIME_HI && a[1:0] == 2'b00;
   endfunction

   localparam int QCW = $clog2(QUEUE_DEPTH + 1);
   localparam int ICW = 40;

   // Bus state.
   logic              aw_hold_ff;
   logic [ADDR_W-1:0] awaddr_ff;
   logic              w_hold_ff;
   logic [31:0]       wdata_ff;
   logic [3:0]        wstrb_ff;
   logic              bvalid_ff;
   logic [1:0]        bresp_ff;
   logic              rvalid_ff;
   logic [31:0]       rdata_ff;
   logic [1:0]        rresp_ff;
   // Configuration registers.
   logic              pte_ff;
   logic [31:0]       dev_key_ff;
   logic [31:0]       grp_key_ff;
   logic [31:0]       grp_mask_ff;
   logic [ACC_W-1:0]  clk_acc_ff;
   logic [MAC_W-1:0]  mac_ff;
   // Time and servo state.
   logic [TS_W-1:0]   time_ff;
   logic [TS_W-1:0]   ms_ff;
   logic              ms_ok_ff;
   logic [TS_W-1:0]   offset_ff;
   logic [TS_W-1:0]   delay_ff;
   logic [ICW-1:0]    ivl_ff;
   logic              dreq_ff;
   sat_srv_t          srv_ff;
   sat_srv_t          nxt_srv;
   logic              tc_valid_ff;
   logic [TS_W-1:0]   tc_corr_ff;
   logic              exp_ff;

   // Register bus handshakes.
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take  = s_axi_wvalid && s_axi_wready;
   wire wr_do   = aw_hold_ff && w_hold_ff && !bvalid_ff;
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire wr_hit  = wr_do && mapped(awaddr_ff);
   wire wr_ctrl = wr_hit && awaddr_ff == OFS_CTRL;
   wire wr_dkey = wr_hit && awaddr_ff == OFS_DEV_KEY;
   wire wr_gkey = wr_hit && awaddr_ff == OFS_GRP_KEY;
   wire wr_gmsk = wr_hit && awaddr_ff == OFS_GRP_MASK;
   wire wr_acc  = wr_hit && awaddr_ff == OFS_CLK_ACC;
   wire wr_mlo  = wr_hit && awaddr_ff == OFS_MAC_LO;
   wire wr_mhi  = wr_hit && awaddr_ff == OFS_MAC_HI;
   wire [31:0] mhi_mrg = merge({16'h0, mac_ff[MAC_W-1:32]}, wdata_ff, wstrb_ff);
   assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
   assign s_axi_wready  = !w_hold_ff && !bvalid_ff;
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

   // Best master selection and message filtering.
   wire [MAC_W-1:0] master_mac;
   wire             self_master;
   sat_bmc u_bmc (
      .aclk           (aclk),
      .aresetn        (aresetn),
      .enable         (pte_ff),
      .self_acc       (clk_acc_ff),
      .self_mac       (mac_ff),
      .ann_valid      (ann_valid),
      .ann_acc        (ann_acc),
      .ann_mac        (ann_mac),
      .master_mac     (master_mac),
      .self_is_master (self_master)
   );
   wire slave_on  = pte_ff && !self_master; // RULE_13
   wire sync_ok   = slave_on && sync_valid && sync_src_mac == master_mac; // RULE_06 RULE_09
   wire dresp_ok  = slave_on && dresp_valid && dresp_src_mac == master_mac && ms_ok_ff; // RULE_09

   // Offset and path delay from the four timestamps.
   wire [TS_W-1:0] ms_now  = sync_t2 - sync_t1;
   wire [TS_W-1:0] sm_now  = dresp_t4 - dresp_t3;
   wire [TS_W-1:0] ofs_sum = ms_ff - sm_now;
   wire [TS_W-1:0] dly_sum = ms_ff + sm_now;
   wire [TS_W-1:0] ofs_now = {ofs_sum[TS_W-1], ofs_sum[TS_W-1:1]}; // RULE_05 RULE_10
   wire [TS_W-1:0] dly_now = {1'b0, dly_sum[TS_W-1:1]}; // RULE_10
   wire [TS_W-1:0] nxt_time = time_ff + CLK_PERIOD_NS - (dresp_ok ? ofs_now : '0); // RULE_11
   wire            synced  = srv_ff == SRV_LOCKED || srv_ff == SRV_MASTER;
   wire            ivl_end = ivl_ff == ICW'(SYNC_INTERVAL_CYC - 1);

   always_comb begin
      nxt_srv = srv_ff;
      unique case (srv_ff)
         SRV_OFF:     if (pte_ff) nxt_srv = self_master ? SRV_MASTER : SRV_ACQUIRE;
         SRV_MASTER:  if (!pte_ff) nxt_srv = SRV_OFF;
                      else if (!self_master) nxt_srv = SRV_ACQUIRE;
         SRV_ACQUIRE: if (!pte_ff) nxt_srv = SRV_OFF;
                      else if (self_master) nxt_srv = SRV_MASTER;
                      else if (dresp_ok) nxt_srv = SRV_LOCKED;
         SRV_LOCKED:  if (!pte_ff) nxt_srv = SRV_OFF;
                      else if (self_master) nxt_srv = SRV_MASTER;
      endcase
   end

   // Scheduled action queue and command filtering.
   wire            q_fire;
   wire            q_full;
   wire [QCW-1:0]  q_count;
   wire key_ok  = act_device_key == dev_key_ff; // RULE_18
   wire grp_ok  = act_group_key == grp_key_ff; // RULE_01
   wire mask_ok = |(act_group_mask & grp_mask_ff); // RULE_02
   wire accept  = act_valid && synced && key_ok && grp_ok && mask_ok; // RULE_14 RULE_15
   wire fire_now = accept && !act_has_time; // RULE_16
   wire q_push   = accept && act_has_time && !q_full; // RULE_17 RULE_19
   sat_queue #(.DEPTH(QUEUE_DEPTH), .TW(TS_W)) u_queue (
      .aclk    (aclk),
      .aresetn (aresetn),
      .push    (q_push),
      .push_ts (act_time),
      .now     (time_ff),
      .fire    (q_fire),
      .count   (q_count),
      .full    (q_full)
   );

   // Read data selection.
   wire [31:0] status_w = {29'h0, q_full, self_master && pte_ff, synced};
   wire [31:0] rd_mux =
      s_axi_araddr == OFS_CTRL        ? {31'h0, pte_ff} :
      s_axi_araddr == OFS_STATUS      ? status_w :
      s_axi_araddr == OFS_DEV_KEY     ? dev_key_ff :
      s_axi_araddr == OFS_GRP_KEY     ? grp_key_ff :
      s_axi_araddr == OFS_GRP_MASK    ? grp_mask_ff :
      s_axi_araddr == OFS_SLOT_SEL    ? SLOT_FIXED : // RULE_03
      s_axi_araddr == OFS_QUEUE_DEPTH ? 32'(QUEUE_DEPTH) : // RULE_04
      s_axi_araddr == OFS_CLK_ACC     ? {24'h0, clk_acc_ff} :
      s_axi_araddr == OFS_MAC_LO      ? mac_ff[31:0] :
      s_axi_araddr == OFS_MAC_HI      ? {16'h0, mac_ff[MAC_W-1:32]} :
      s_axi_araddr == OFS_OFFSET      ? offset_ff[31:0] :
      s_axi_araddr == OFS_DELAY       ? delay_ff[31:0] :
      s_axi_araddr == OFS_TIME_LO     ? time_ff[31:0] :
      s_axi_araddr == OFS_TIME_HI     ? time_ff[63:32] : 32'h0;

   // Bus channel registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_ff <= 1'b0;
         w_hold_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         rvalid_ff  <= 1'b0;
      end else begin
         aw_hold_ff <= wr_do ? 1'b0 : (aw_hold_ff || aw_take);
         w_hold_ff  <= wr_do ? 1'b0 : (w_hold_ff || w_take);
         bvalid_ff  <= wr_do ? 1'b1 : (bvalid_ff && !s_axi_bready);
         rvalid_ff  <= ar_take ? 1'b1 : (rvalid_ff && !s_axi_rready);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awaddr_ff <= '0;
         wdata_ff  <= 32'h0;
         wstrb_ff  <= 4'h0;
         bresp_ff  <= RESP_OKAY;
         rdata_ff  <= 32'h0;
         rresp_ff  <= RESP_OKAY;
      end else begin
         if (aw_take) awaddr_ff <= s_axi_awaddr;
         if (w_take) wdata_ff <= s_axi_wdata;
         if (w_take) wstrb_ff <= s_axi_wstrb;
         if (wr_do) bresp_ff <= mapped(awaddr_ff) ? RESP_OKAY : RESP_DECERR;
         if (ar_take) rdata_ff <= rd_mux;
         if (ar_take) rresp_ff <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
      end
   end

   // Configuration registers; slot select and queue depth ignore writes.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pte_ff      <= 1'b0;
         dev_key_ff  <= KEY_RST;
         grp_key_ff  <= KEY_RST;
         grp_mask_ff <= KEY_RST;
         clk_acc_ff  <= CLK_ACC_RST;
         mac_ff      <= MAC_RST;
      end else begin
         if (wr_ctrl && wstrb_ff[0]) pte_ff <= wdata_ff[CTRL_PTE_BIT]; // RULE_13
         if (wr_dkey) dev_key_ff <= merge(dev_key_ff, wdata_ff, wstrb_ff);
         if (wr_gkey) grp_key_ff <= merge(grp_key_ff, wdata_ff, wstrb_ff);
         if (wr_gmsk) grp_mask_ff <= merge(grp_mask_ff, wdata_ff, wstrb_ff);
         if (wr_acc && wstrb_ff[0]) clk_acc_ff <= wdata_ff[ACC_W-1:0];
         if (wr_mlo) mac_ff[31:0] <= merge(mac_ff[31:0], wdata_ff, wstrb_ff);
         if (wr_mhi) mac_ff[MAC_W-1:32] <= mhi_mrg[MAC_W-33:0];
      end
   end

   // Local time, servo and periodic delay requests.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         time_ff   <= '0;
         ms_ff     <= '0;
         ms_ok_ff  <= 1'b0;
         offset_ff <= '0;
         delay_ff  <= '0;
         ivl_ff    <= '0;
         dreq_ff   <= 1'b0;
         srv_ff    <= SRV_OFF;
      end else begin
         time_ff   <= nxt_time;
         srv_ff    <= nxt_srv;
         if (sync_ok) ms_ff <= ms_now; // RULE_10
         ms_ok_ff  <= slave_on && (ms_ok_ff || sync_ok);
         if (dresp_ok) offset_ff <= ofs_now; // RULE_11
         if (dresp_ok) delay_ff <= dly_now; // RULE_10
         ivl_ff    <= (!slave_on || ivl_end) ? '0 : ivl_ff + 1'b1; // RULE_12
         dreq_ff   <= slave_on && ms_ok_ff && ivl_end; // RULE_12
      end
   end
   assign delay_req_start = dreq_ff;
   assign local_time      = time_ff;

   // Transparent clock correction and exposure start.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tc_valid_ff <= 1'b0;
         tc_corr_ff  <= '0;
         exp_ff      <= 1'b0;
      end else begin
         tc_valid_ff <= tc_valid && pte_ff; // RULE_08
         if (tc_valid) tc_corr_ff <= tc_corr_in + (tc_egress_ts - tc_ingress_ts); // RULE_08
         exp_ff      <= fire_now || q_fire; // RULE_15 RULE_16 RULE_17
      end
   end
   assign tc_corr_valid  = tc_valid_ff;
   assign tc_corr_out    = tc_corr_ff;
   assign exposure_start = exp_ff;
endmodule

// ---- sat_asserts.sv ----
/* Port checks for sat_top.
   Bound to every sat_top instance. */
`timescale 1ns/100ps
module sat_asserts (
   // Clock and reset.
   input wire logic        aclk, aresetn,
   // Handshakes and pulses.
   input wire logic        s_axi_awready, s_axi_arready, s_axi_bvalid, s_axi_bready,
   input wire logic        s_axi_rvalid, s_axi_rready, tc_valid, tc_corr_valid,
   input wire logic        dresp_valid, delay_req_start,
   // Data.
   input wire logic [1:0]  s_axi_bresp,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [63:0] local_time, tc_corr_in, tc_ingress_ts, tc_egress_ts, tc_corr_out
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw ready early");
   a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar ready early");
   a_tc_sum: assert property (tc_valid |=> tc_corr_out ==
      $past(tc_corr_in) + $past(tc_egress_ts) - $past(tc_ingress_ts)) else $error("tc sum");
   a_tc_cause: assert property (tc_corr_valid |-> $past(tc_valid))
      else $error("tc pulse without cause");
   a_time_step: assert property ($past(aresetn) && !$past(dresp_valid)
      |-> local_time == $past(local_time) + 64'h8) else $error("time step");
   a_req_gap: assert property (delay_req_start |=> !delay_req_start [*8])
      else $error("requests too close");
endmodule
bind sat_top sat_asserts chk (.*);

// ---- sat_ptp_master.sv ----
/* Master clock model: announces, sends sync and answers delay requests.
   Shares the clock of sat_top. */
`timescale 1ns/100ps
module sat_ptp_master #(
   parameter int          LAT = 3,
   parameter int          DLY = 40,
   parameter logic [47:0] MAC = 48'h0000_0a0b_0c0d
) (
   // Clock and slave side.
   input wire logic        aclk, delay_req_start,
   input wire logic [63:0] local_time,
   // Messages.
   output logic            ann_valid, sync_valid, dresp_valid,
   output logic [7:0]      ann_acc,
   output logic [47:0]     ann_mac, sync_src_mac, dresp_src_mac,
   output logic [63:0]     sync_t1, sync_t2, dresp_t3, dresp_t4
);
   logic [63:0] mt = 64'h100_0000;
   int          cnt = 0;
   int          wt = -1;
   assign {ann_acc, ann_mac, sync_src_mac, dresp_src_mac} = {8'h20, {3{MAC}}};
   always @(posedge aclk) begin
      mt <= mt + 64'h8;
      cnt <= cnt + 1;
      wt <= delay_req_start ? LAT : wt - 1;
      ann_valid <= cnt % 64 == 1;
      sync_valid <= cnt % 64 == 3 || delay_req_start;
      sync_t1 <= mt;
      sync_t2 <= local_time + DLY;
      dresp_valid <= wt == 0;
      if (delay_req_start) begin
         dresp_t3 <= local_time;
         dresp_t4 <= mt + DLY;
      end
   end
endmodule

// ---- tb.sv ----
/* Self-checking bench for sat_top.
   Needs sat_pkg, sat_top, sat_ptp_master and sat_asserts. */
`timescale 1ns/100ps
module tb;
   import sat_pkg::*;
   logic aclk = '0, aresetn = '0, tc_valid = '0, act_valid = '0, act_has_time = '0;
   logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '1;
   logic s_axi_arvalid = '0, s_axi_rready = '1;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, act_device_key = '0, act_group_key = '0, act_group_mask = '0;
   logic [63:0] tc_ingress_ts = '0, tc_egress_ts = '0, tc_corr_in = '0, act_time = '0, t0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, delay_req_start;
   wire ann_valid, sync_valid, dresp_valid, tc_corr_valid, exposure_start;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [7:0] ann_acc;
   wire [31:0] s_axi_rdata;
   wire [47:0] ann_mac, sync_src_mac, dresp_src_mac;
   wire [63:0] sync_t1, sync_t2, dresp_t3, dresp_t4, tc_corr_out, local_time;
   logic [31:0] rdv, kd, kg, km, dk, gk, gm;
   logic [1:0] rs;
   logic [7:0] ra[4] = '{OFS_CLK_ACC, OFS_SLOT_SEL, OFS_QUEUE_DEPTH, OFS_DEV_KEY};
   logic [31:0] re[4] = '{32'hfe, 32'h0, 32'h4, 32'h0};
   int num_errors = 0, n_checks = 0, cyc = 0, nexp = 0, ndrq = 0, nb, db, seed = 32'h0f4d;
   logic [63:0] tq[$];
   sat_top #(.SYNC_INTERVAL_CYC(20), .QUEUE_DEPTH(4)) dut (.*);
   sat_ptp_master #(.LAT(3), .DLY(40)) p (.*);
   always #4 aclk = ~aclk;
   task automatic chk(input logic [63:0] g, e);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rs = s_axi_bresp;
   endtask
   task rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rdv = s_axi_rdata;
      rs = s_axi_rresp;
   endtask
   task act(input logic [31:0] d, g, m, input logic h, input logic [63:0] t);
      @(posedge aclk);
      {act_valid, act_has_time, act_time} <= {1'b1, h, t};
      {act_device_key, act_group_key, act_group_mask} <= {d, g, m};
      @(posedge aclk);
      act_valid <= 1'b0;
   endtask
   always @(negedge aclk) begin
      ndrq += delay_req_start;
      if (exposure_start === 1'b1 && tq.size() > 0) begin
         chk(local_time >= tq[0] && local_time <= tq[0] + 24, 1'b1);
         void'(tq.pop_front());
      end
      nexp += exposure_start === 1'b1;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      wr(OFS_SLOT_SEL, 32'h5);
      for (int i = 0; i < 4; i++) begin
         rd(ra[i]);
         chk({rs, rdv}, {RESP_OKAY, re[i]});
      end
      rd(8'h40);
      chk({rs, rdv}, {RESP_DECERR, 32'h0});
      kd = $random(seed);
      kg = $random(seed);
      km = $random(seed) | 32'h1;
      wr(OFS_DEV_KEY, kd);
      wr(OFS_GRP_KEY, kg);
      wr(OFS_GRP_MASK, km);
      act(kd, kg, km, 1'b0, '0);
      @(negedge aclk);
      chk(exposure_start, 1'b0);
      repeat (150) @(posedge aclk);
      rd(OFS_STATUS);
      chk(rdv[ST_SYNC_BIT], 1'b0);
      $display("done: registers");
      wr(OFS_CTRL, 32'h1);
      do rd(OFS_STATUS); while (rdv[1:0] !== 2'h1);
      repeat (30) @(negedge aclk);
      chk(local_time - p.mt + 8 <= 16, 1'b1);
      rd(OFS_DELAY);
      chk(rdv, 32'h28);
      rd(OFS_STATUS);
      chk(rdv[ST_MASTER_BIT], 1'b0);
      for (int i = 0; i < 16; i++) begin
         dk = i % 4 == 1 ? ~kd : kd;
         gk = i % 4 == 2 ? ~kg : kg;
         gm = i % 4 == 3 ? ~km : $random(seed);
         act(dk, gk, gm, 1'b0, '0);
         @(negedge aclk);
         chk(exposure_start, dk == kd && gk == kg && (gm & km) != 0);
      end
      $display("done: filter");
      {nb, db} = {nexp, ndrq};
      t0 = local_time + 64'h190;
      for (int i = 0; i < 5; i++) begin
         if (i < 4) tq.push_back(t0 + 64'h50 * i);
         act(kd, kg, km, 1'b1, t0 + 64'h50 * i);
      end
      rd(OFS_STATUS);
      chk(rdv[ST_QFULL_BIT], 1'b1);
      repeat (150) @(posedge aclk);
      chk(nexp - nb, 4);
      chk(ndrq - db >= 2, 1'b1);
      $display("done: timed");
      @(posedge aclk);
      {tc_valid, tc_corr_in, tc_egress_ts, tc_ingress_ts} <= {1'b1, {6{$random(seed)}}};
      @(posedge aclk);
      tc_valid <= 1'b0;
      @(negedge aclk);
      chk({tc_corr_valid, tc_corr_out}, {1'b1, tc_corr_in + tc_egress_ts - tc_ingress_ts});
      wr(OFS_CLK_ACC, 32'h20);
      wr(OFS_MAC_LO, 32'h1);
      wr(OFS_MAC_HI, 32'h0);
      repeat (70) @(posedge aclk);
      rd(OFS_STATUS);
      chk(rdv[ST_MASTER_BIT], 1'b1);
      wr(OFS_MAC_LO, 32'hffff_ffff);
      wr(OFS_MAC_HI, 32'hffff);
      repeat (70) @(posedge aclk);
      rd(OFS_STATUS);
      chk(rdv[ST_MASTER_BIT], 1'b0);
      $display("done: clocks");
      report_and_stop();
   end
endmodule
